// File: rtl/qcs_pkg.sv
/*
 * qcs_pkg: register map, field positions, reset values and mode codes
 * for the queue classifier and scheduler.
 * Assumes one clock domain and a word-aligned register port.
 */
// How it works
// - every frame lands in one of four egress queues, numbered 0 to 3
// - a global mode picks port default, 802.1p class, or DSCP as source
// - strict priority always serves the highest non-empty queue first
// - round robin uses one programmable weight per queue, largest 10
// - round robin share of queue x is its weight over the weight sum
// - port mode gives each frame its port default; queue 3 highest
// - port-mode queue choice never changes the frame itself
// - class map resets to 1,2->0; 0,3->1; 4,5->2; 6,7->3
// - software may rewrite each of the eight class map entries
// - class mode indexes the map with the 3-bit tag priority
// - a writable map sends each DSCP value to one queue
// - DSCP mode indexes that map with the six-bit DiffServ field
// - strict ranking is queue 3, then 2, then 1, then 0
package qcs_pkg;

    localparam int ADDR_W = 12;
    localparam int DSCP_N = 64;

    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] WGT_OFS = 12'h004;
    localparam logic [11:0] COS_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS = 12'h00C;
    localparam logic [11:0] PMAP_BASE = 12'h100;
    localparam logic [11:0] DMAP_BASE = 12'h200;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_WRR_BIT = 2;
    localparam int STAT_LAST_LSB = 0;
    localparam int STAT_PTR_LSB = 2;
    localparam int STAT_NE_LSB = 4;
    localparam int STAT_CRED_LSB = 16;

    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_COS = 2'h1;
    localparam logic [1:0] MODE_DSCP = 2'h2;

    localparam logic [3:0] W_MAX = 4'hA;
    localparam logic [15:0] WGT_RESET = 16'h1111;
    localparam logic [15:0] COS_RESET = 16'hFA41;
    localparam logic [127:0] DSCP_RESET =
        128'hFFFF_FFFF_AAAA_AAAA_5555_0000_0000_5555;

endpackage

// File: rtl/qcs_map_if.sv
/*
 * qcs_map_if: write port and two read ports of a queue map memory.
 * Assumes all signals are on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

interface qcs_map_if #(
    parameter int AW = 6
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [1:0] wr_data;
    logic [AW-1:0] a_addr;
    logic [1:0] a_data;
    logic [AW-1:0] b_addr;
    logic [1:0] b_data;

    modport mem (
        input wr_en, wr_addr, wr_data, a_addr, b_addr,
        output a_data, b_data
    );
    modport user (
        output wr_en, wr_addr, wr_data, a_addr, b_addr,
        input a_data, b_data
    );
endinterface // qcs_map_if

`default_nettype wire

// File: rtl/qcs_map_mem.sv
/*
 * qcs_map_mem: small two-bit-wide map memory with reset image,
 * one write port and two registered read ports.
 * Assumes addresses past DEPTH are filtered or read as zero.
 */
`timescale 1ns/1ps
`default_nettype none

module qcs_map_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter logic [2*DEPTH-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    qcs_map_if.mem m
);
    logic [1:0] ram_q [DEPTH];

    generate
        if (DEPTH < 1 || DEPTH > 2**AW) begin : g_chk
            $error("map depth does not fit address width");
        end
    endgenerate

    function automatic logic [1:0] rd(input logic [AW-1:0] a);
        return (int'(a) < DEPTH) ? ram_q[a] : 2'h0;
    endfunction

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                ram_q[i] <= INIT[2*i +: 2];
            end
        end else if (m.wr_en && int'(m.wr_addr) < DEPTH) begin
            ram_q[m.wr_addr] <= m.wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            m.a_data <= 2'h0;
            m.b_data <= 2'h0;
        end else begin
            m.a_data <= rd(m.a_addr);
            m.b_data <= rd(m.b_addr);
        end
    end
endmodule // qcs_map_mem

`default_nettype wire

// File: rtl/qcs_classifier_scheduler.sv
/*
 * qcs_classifier_scheduler: per-frame queue classification and egress
 * queue scheduling, with its configuration registers.
 * Assumes parsed headers arrive on core_clk with no back-pressure and
 * that the egress side pops the granted queue on deq_valid.
 */
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module qcs_classifier_scheduler #(
    parameter int NUM_PORTS = 28,
    parameter int PORT_W = 5
) (
    input wire logic core_clk,
    input wire logic rst,

    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,

    input wire logic hdr_valid,
    input wire logic [PORT_W-1:0] hdr_port,
    input wire logic hdr_tagged,
    input wire logic [2:0] hdr_pcp,
    input wire logic hdr_ipv4,
    input wire logic [5:0] hdr_dscp,

    output logic enq_valid,
    output logic [PORT_W-1:0] enq_port,
    output logic [1:0] enq_queue,

    input wire logic [3:0] q_nonempty,
    input wire logic tx_ready,
    output logic deq_valid,
    output logic [1:0] deq_queue
);

    generate
        if (NUM_PORTS < 1 || NUM_PORTS > 2**PORT_W || PORT_W > 6) begin : g_chk
            $error("port count does not fit port width or map space");
        end
    endgenerate

    localparam logic [1:0] RD_REG = 2'h0;
    localparam logic [1:0] RD_PMAP = 2'h1;
    localparam logic [1:0] RD_DMAP = 2'h2;

    // configuration state
    logic [1:0] mode_q;
    logic wrr_q;
    logic [3:0][3:0] wgt_q;
    logic [15:0] cos_q;

    // classifier pipeline
    logic s1_valid_q;
    logic [PORT_W-1:0] s1_port_q;
    logic s1_tagged_q;
    logic [2:0] s1_pcp_q;
    logic s1_ipv4_q;
    logic [1:0] s1_mode_q;
    logic [1:0] cls_d;
    logic enq_valid_q;
    logic [PORT_W-1:0] enq_port_q;
    logic [1:0] enq_queue_q;

    // scheduler
    logic [3:0][3:0] credit_q;
    logic [1:0] ptr_q;
    logic [3:0] elig;
    logic sp_found;
    logic [1:0] sp_idx;
    logic rr_found;
    logic [1:0] rr_idx;
    logic gnt_found;
    logic [1:0] gnt_idx;
    logic go;
    logic reload;
    logic deq_valid_q;
    logic [1:0] deq_queue_q;
    logic [1:0] last_q;

    // register read path
    logic [1:0] rd_src_q;
    logic [31:0] rdata_q;
    logic [31:0] plain_rd;
    logic pm_hit;
    logic dm_hit;

    qcs_map_if #(.AW(PORT_W)) pm_if ();
    qcs_map_if #(.AW(6)) dm_if ();

    function automatic logic in_map(
        input logic [11:0] a,
        input logic [11:0] base
    );
        return a[11:8] == base[11:8] && a[1:0] == 2'h0;
    endfunction

    function automatic logic [3:0] clamp_w(input logic [3:0] w);
        return (w > qcs_pkg::W_MAX) ? qcs_pkg::W_MAX : w;
    endfunction

    // later hits override earlier ones, so the top set bit wins
    function automatic logic [2:0] pick_hi(input logic [3:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 0; k < 4; k++) begin
            if (m[k]) begin
                r = {1'b1, 2'(k)};
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] pick_rr(
        input logic [3:0] m,
        input logic [1:0] p
    );
        logic [2:0] r;
        logic [1:0] idx;
        r = 3'h0;
        for (int k = 3; k >= 0; k--) begin
            idx = p + 2'(k);
            if (m[idx]) begin
                r = {1'b1, idx};
            end
        end
        return r;
    endfunction

    assign pm_hit = in_map(reg_addr, qcs_pkg::PMAP_BASE)
        && int'(reg_addr[7:2]) < NUM_PORTS;
    assign dm_hit = in_map(reg_addr, qcs_pkg::DMAP_BASE);

    assign pm_if.wr_en = reg_wr && pm_hit;
    assign pm_if.wr_addr = reg_addr[2 +: PORT_W];
    assign pm_if.wr_data = reg_wdata[1:0];
    assign pm_if.b_addr = reg_addr[2 +: PORT_W];
    assign pm_if.a_addr = hdr_port;

    assign dm_if.wr_en = reg_wr && dm_hit;
    assign dm_if.wr_addr = reg_addr[7:2];
    assign dm_if.wr_data = reg_wdata[1:0];
    assign dm_if.b_addr = reg_addr[7:2];
    assign dm_if.a_addr = hdr_dscp;

    qcs_map_mem #(
        .DEPTH(NUM_PORTS),
        .AW(PORT_W),
        .INIT('0)
    ) u_port_map (
        .core_clk(core_clk),
        .rst(rst),
        .m(pm_if)
    );

    qcs_map_mem #(
        .DEPTH(qcs_pkg::DSCP_N),
        .AW(6),
        .INIT(qcs_pkg::DSCP_RESET)
    ) u_dscp_map (
        .core_clk(core_clk),
        .rst(rst),
        .m(dm_if)
    );

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= qcs_pkg::MODE_PORT;
            wrr_q <= 1'b0;
        end else if (reg_wr && reg_addr == qcs_pkg::CTRL_OFS) begin
            mode_q <= reg_wdata[qcs_pkg::CTRL_MODE_LSB +: 2];
            wrr_q <= reg_wdata[qcs_pkg::CTRL_WRR_BIT];
        end
    end

    // weights saturate at the largest legal value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wgt_q <= qcs_pkg::WGT_RESET;
        end else if (reg_wr && reg_addr == qcs_pkg::WGT_OFS) begin
            for (int i = 0; i < 4; i++) begin
                wgt_q[i] <= clamp_w(reg_wdata[4*i +: 4]);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cos_q <= qcs_pkg::COS_RESET;
        end else if (reg_wr && reg_addr == qcs_pkg::COS_OFS) begin
            cos_q <= reg_wdata[15:0];
        end
    end

    // stage 1 waits for the map memories' registered read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_valid_q <= 1'b0;
            s1_port_q <= '0;
            s1_tagged_q <= 1'b0;
            s1_pcp_q <= 3'h0;
            s1_ipv4_q <= 1'b0;
            s1_mode_q <= qcs_pkg::MODE_PORT;
        end else begin
            s1_valid_q <= hdr_valid;
            if (hdr_valid) begin
                s1_port_q <= hdr_port;
                s1_tagged_q <= hdr_tagged;
                s1_pcp_q <= hdr_pcp;
                s1_ipv4_q <= hdr_ipv4;
                s1_mode_q <= mode_q;
            end
        end
    end

    // source select; code 3 behaves as port mode
    always_comb begin
        cls_d = pm_if.a_data;
        case (s1_mode_q)
            qcs_pkg::MODE_COS: begin
                if (s1_tagged_q) begin
                    cls_d = cos_q[2*s1_pcp_q +: 2];
                end
            end
            qcs_pkg::MODE_DSCP: begin
                if (s1_ipv4_q) begin
                    cls_d = dm_if.a_data;
                end
            end
            default: begin
                cls_d = pm_if.a_data;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            enq_valid_q <= 1'b0;
            enq_port_q <= '0;
            enq_queue_q <= 2'h0;
        end else begin
            enq_valid_q <= s1_valid_q;
            if (s1_valid_q) begin
                enq_port_q <= s1_port_q;
                enq_queue_q <= cls_d;
            end
        end
    end

    // no remark output
    // only the queue is reported; the frame body is never rewritten,
    // so port-mode priority does not leave the switch
    assign enq_valid = enq_valid_q;
    assign enq_port = enq_port_q;
    assign enq_queue = enq_queue_q;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            elig[i] = q_nonempty[i] && credit_q[i] != 4'h0;
        end
        {sp_found, sp_idx} = pick_hi(q_nonempty);
        {rr_found, rr_idx} = pick_rr(elig, ptr_q);
        gnt_found = wrr_q ? rr_found : sp_found;
        gnt_idx = wrr_q ? rr_idx : sp_idx;
    end

    assign go = tx_ready && gnt_found;
    // a refill costs one request with no grant; cheaper than a
    // second picker that looks at the refilled credits
    assign reload = wrr_q && tx_ready && !rr_found && q_nonempty != 4'h0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            credit_q <= qcs_pkg::WGT_RESET;
            ptr_q <= 2'h0;
        end else if (reload) begin
            credit_q <= wgt_q;
        end else if (go && wrr_q) begin
            credit_q[gnt_idx] <= credit_q[gnt_idx] - 4'h1;
            if (credit_q[gnt_idx] == 4'h1) begin
                ptr_q <= gnt_idx + 2'h1;
            end else begin
                ptr_q <= gnt_idx;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            deq_valid_q <= 1'b0;
            deq_queue_q <= 2'h0;
            last_q <= 2'h0;
        end else begin
            deq_valid_q <= go;
            if (go) begin
                deq_queue_q <= gnt_idx;
                last_q <= gnt_idx;
            end
        end
    end

    assign deq_valid = deq_valid_q;
    assign deq_queue = deq_queue_q;

    always_comb begin
        plain_rd = 32'h0;
        case (reg_addr)
            qcs_pkg::CTRL_OFS: begin
                plain_rd[qcs_pkg::CTRL_MODE_LSB +: 2] = mode_q;
                plain_rd[qcs_pkg::CTRL_WRR_BIT] = wrr_q;
            end
            qcs_pkg::WGT_OFS: begin
                plain_rd[15:0] = wgt_q;
            end
            qcs_pkg::COS_OFS: begin
                plain_rd[15:0] = cos_q;
            end
            qcs_pkg::STAT_OFS: begin
                plain_rd[qcs_pkg::STAT_LAST_LSB +: 2] = last_q;
                plain_rd[qcs_pkg::STAT_PTR_LSB +: 2] = ptr_q;
                plain_rd[qcs_pkg::STAT_NE_LSB +: 4] = q_nonempty;
                plain_rd[qcs_pkg::STAT_CRED_LSB +: 16] = credit_q;
            end
            default: begin
                plain_rd = 32'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_src_q <= RD_REG;
            rdata_q <= 32'h0;
        end else if (reg_rd) begin
            rdata_q <= plain_rd;
            rd_src_q <= pm_hit ? RD_PMAP : (dm_hit ? RD_DMAP : RD_REG);
        end
    end

    always_comb begin
        case (rd_src_q)
            RD_PMAP: reg_rdata = {30'h0, pm_if.b_data};
            RD_DMAP: reg_rdata = {30'h0, dm_if.b_data};
            default: reg_rdata = rdata_q;
        endcase
    end

    a_wgt_max:
    assert property (@(posedge core_clk) disable iff (rst)
        wgt_q[0] <= 4'hA && wgt_q[1] <= 4'hA
        && wgt_q[2] <= 4'hA && wgt_q[3] <= 4'hA)
    else $error("queue weight above ten");

    a_strict_order:
    assert property (@(posedge core_clk) disable iff (rst)
        $past(!wrr_q) && deq_valid_q |->
        ($past(q_nonempty) & ~((4'h2 << deq_queue_q) - 4'h1)) == 4'h0)
    else $error("strict grant skipped a higher busy queue");

    a_strict_top:
    assert property (@(posedge core_clk) disable iff (rst)
        !wrr_q && tx_ready && q_nonempty[3] |=>
        deq_valid_q && deq_queue_q == 2'h3)
    else $error("queue 3 not served first");

    a_wrr_refill:
    assert property (@(posedge core_clk) disable iff (rst)
        wrr_q && tx_ready && q_nonempty != 4'h0 && elig == 4'h0 |=>
        credit_q == $past(wgt_q) && !deq_valid_q)
    else $error("credits not refilled from weights");

    a_port_mode:
    assert property (@(posedge core_clk) disable iff (rst)
        s1_valid_q && (s1_mode_q == 2'h0 || s1_mode_q == 2'h3) |=>
        enq_valid_q && enq_queue_q == $past(pm_if.a_data))
    else $error("port mode ignored port default");

    a_cos_index:
    assert property (@(posedge core_clk) disable iff (rst)
        s1_valid_q && s1_mode_q == 2'h1 && s1_tagged_q |=>
        enq_queue_q == $past(cos_q[2*s1_pcp_q +: 2]))
    else $error("class map lookup wrong");

    a_dscp_index:
    assert property (@(posedge core_clk) disable iff (rst)
        s1_valid_q && s1_mode_q == 2'h2 && s1_ipv4_q |=>
        enq_queue_q == $past(dm_if.a_data))
    else $error("dscp map lookup wrong");

    a_fallback:
    assert property (@(posedge core_clk) disable iff (rst)
        s1_valid_q && ((s1_mode_q == 2'h1 && !s1_tagged_q)
        || (s1_mode_q == 2'h2 && !s1_ipv4_q)) |=>
        enq_queue_q == $past(pm_if.a_data))
    else $error("missing field did not fall back");

    a_cos_reset:
    assert property (@(posedge core_clk)
        $past(rst) && !rst |-> cos_q == 16'hFA41)
    else $error("class map reset image wrong");

    a_two_cycle:
    assert property (@(posedge core_clk) disable iff (rst)
        hdr_valid |-> ##2 enq_valid_q)
    else $error("classification latency not two");

endmodule // qcs_classifier_scheduler

`default_nettype wire

// File: test/qcs_egress_model.sv
/*
 * qcs_egress_model: occupancy counters of the four egress queues, pushed by
 * classification results and popped by scheduler grants.
 * Assumes one clock, at most one push and one pop per queue per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module qcs_egress_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic enq_valid,
    input wire logic [1:0] enq_queue,
    input wire logic deq_valid,
    input wire logic [1:0] deq_queue,
    output logic [3:0] q_nonempty,
    output logic pop_err
);
    logic [7:0] cnt_q [4];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (enq_valid && enq_queue == 2'(i) && !(deq_valid && deq_queue == 2'(i))) begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end else if (deq_valid && deq_queue == 2'(i) && !(enq_valid && enq_queue == 2'(i))) begin
                    cnt_q[i] <= cnt_q[i] - 8'h01;
                end
            end
        end
    end

    // a grant on an empty queue would pop nothing; latch it for the bench
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pop_err <= 1'b0;
        end else if (deq_valid && cnt_q[deq_queue] == 8'h00) begin
            pop_err <= 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            q_nonempty[i] = (cnt_q[i] != 8'h00);
        end
    end
endmodule // qcs_egress_model

`default_nettype wire

// File: test/tb_qos_queue_classifier_scheduler.sv
/*
 * tb_qos_queue_classifier_scheduler: directed bench for classification
 * modes, map reset images and both schedulers.
 * Assumes the egress model drains the queue named by each grant.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_qos_queue_classifier_scheduler;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic hdr_valid = 1'b0;
    logic [4:0] hdr_port = 5'h00;
    logic hdr_tagged = 1'b0;
    logic [2:0] hdr_pcp = 3'h0;
    logic hdr_ipv4 = 1'b0;
    logic [5:0] hdr_dscp = 6'h00;
    logic enq_valid;
    logic [4:0] enq_port;
    logic [1:0] enq_queue;
    logic [3:0] q_nonempty;
    logic tx_ready = 1'b0;
    logic deq_valid;
    logic [1:0] deq_queue;
    logic pop_err;
    int err_total = 0;
    int checked = 0;
    int dsv [10] = '{0, 7, 8, 23, 24, 31, 32, 47, 48, 63};
    logic [1:0] dsq [10] = '{1, 1, 0, 0, 1, 1, 2, 2, 3, 3};
    logic [1:0] cosq [8] = '{1, 0, 0, 1, 2, 2, 3, 3};

    always #2.5 core_clk = ~core_clk;

    qcs_classifier_scheduler #(.NUM_PORTS(28), .PORT_W(5)) dut_u (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .hdr_valid(hdr_valid), .hdr_port(hdr_port), .hdr_tagged(hdr_tagged),
        .hdr_pcp(hdr_pcp), .hdr_ipv4(hdr_ipv4), .hdr_dscp(hdr_dscp),
        .enq_valid(enq_valid), .enq_port(enq_port), .enq_queue(enq_queue),
        .q_nonempty(q_nonempty), .tx_ready(tx_ready), .deq_valid(deq_valid),
        .deq_queue(deq_queue)
    );

    qcs_egress_model egress_u (
        .core_clk(core_clk), .rst(rst), .enq_valid(enq_valid), .enq_queue(enq_queue),
        .deq_valid(deq_valid), .deq_queue(deq_queue), .q_nonempty(q_nonempty),
        .pop_err(pop_err)
    );

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand from the cycle after the strobe onward
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp, "register read");
    endtask

    // result is due exactly two edges after the header is driven
    task automatic send(input logic [4:0] p, input logic tg, input logic [2:0] pcp,
                        input logic ip, input logic [5:0] ds, input logic [1:0] q);
        @(posedge core_clk);
        hdr_valid <= 1'b1;
        hdr_port <= p;
        hdr_tagged <= tg;
        hdr_pcp <= pcp;
        hdr_ipv4 <= ip;
        hdr_dscp <= ds;
        @(posedge core_clk);
        hdr_valid <= 1'b0;
        @(posedge core_clk);
        #1;
        cmp({24'h0, enq_port, enq_valid, enq_queue}, {24'h0, p, 1'b1, q}, "classification");
    endtask

    // one spare edge lets the egress model pop before the next request
    task automatic grant(input logic v, input logic [1:0] q);
        @(posedge core_clk);
        tx_ready <= 1'b1;
        @(posedge core_clk);
        tx_ready <= 1'b0;
        #1;
        cmp({29'h0, deq_valid, v ? deq_queue : 2'h0}, {29'h0, v, q}, "grant");
        @(posedge core_clk);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    task automatic fill(input int n);
        for (int i = 0; i < 4; i++) begin
            wr(qcs_pkg::PMAP_BASE + 12'(4 * i), 32'(i));
        end
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < n; k++) begin
                send(5'(i), 1'b0, 3'h0, 1'b0, 6'h00, 2'(i));
            end
        end
    endtask

    task automatic t_reset_values();
        rd(qcs_pkg::CTRL_OFS, 32'h0);
        rd(qcs_pkg::WGT_OFS, 32'h0000_1111);
        rd(qcs_pkg::COS_OFS, 32'h0000_FA41);
        for (int i = 0; i < 10; i++) begin
            rd(qcs_pkg::DMAP_BASE + 12'(4 * dsv[i]), {30'h0, dsq[i]});
        end
        wr(12'h010, 32'hFFFF_FFFF);
        rd(12'h010, 32'h0);
        rd(qcs_pkg::PMAP_BASE + 12'(4 * 28), 32'h0);
        $display("test reset_values done");
    endtask

    task automatic t_port_mode();
        wr(qcs_pkg::PMAP_BASE + 12'(4 * 3), 32'h3);
        wr(qcs_pkg::PMAP_BASE + 12'(4 * 27), 32'h2);
        send(5'd3, 1'b1, 3'h1, 1'b1, 6'h00, 2'h3);
        send(5'd27, 1'b1, 3'h7, 1'b1, 6'h3F, 2'h2);
        send(5'd4, 1'b0, 3'h7, 1'b0, 6'h3F, 2'h0);
        $display("test port_mode done");
    endtask

    task automatic t_cos_mode();
        wr(qcs_pkg::CTRL_OFS, 32'h1);
        for (int i = 0; i < 8; i++) begin
            send(5'd4, 1'b1, 3'(i), 1'b0, 6'h00, cosq[i]);
        end
        send(5'd3, 1'b0, 3'h1, 1'b1, 6'h00, 2'h3);
        wr(qcs_pkg::COS_OFS, 32'h0000_1B1B);
        rd(qcs_pkg::COS_OFS, 32'h0000_1B1B);
        send(5'd4, 1'b1, 3'h0, 1'b0, 6'h00, 2'h3);
        send(5'd4, 1'b1, 3'h6, 1'b0, 6'h00, 2'h1);
        $display("test cos_mode done");
    endtask

    task automatic t_dscp_mode();
        wr(qcs_pkg::CTRL_OFS, 32'h2);
        for (int i = 0; i < 10; i++) begin
            send(5'd4, 1'b1, 3'h7, 1'b1, 6'(dsv[i]), dsq[i]);
        end
        send(5'd27, 1'b1, 3'h7, 1'b0, 6'h3F, 2'h2);
        wr(qcs_pkg::DMAP_BASE + 12'(4 * 5), 32'hFFFF_FFFF);
        rd(qcs_pkg::DMAP_BASE + 12'(4 * 5), 32'h3);
        send(5'd4, 1'b0, 3'h0, 1'b1, 6'd5, 2'h3);
        // spare mode code must behave as port mode
        wr(qcs_pkg::CTRL_OFS, 32'h3);
        send(5'd27, 1'b1, 3'h7, 1'b1, 6'h3F, 2'h2);
        $display("test dscp_mode done");
    endtask

    // earlier tests left frames in the egress model; start from empty queues
    task automatic t_strict();
        do_reset();
        wr(qcs_pkg::CTRL_OFS, 32'h0);
        wr(qcs_pkg::WGT_OFS, 32'h0000_F321);
        rd(qcs_pkg::WGT_OFS, 32'h0000_A321);
        fill(1);
        send(5'd2, 1'b0, 3'h0, 1'b0, 6'h00, 2'h2);
        grant(1'b1, 2'h3);
        grant(1'b1, 2'h2);
        grant(1'b1, 2'h2);
        grant(1'b1, 2'h1);
        grant(1'b1, 2'h0);
        grant(1'b0, 2'h0);
        cmp({31'h0, pop_err}, 32'h0, "pop of empty queue");
        $display("test strict done");
    endtask

    // weights {1,1,1,2}: q3 gets two of every five grants
    task automatic t_wrr();
        do_reset();
        fill(3);
        wr(qcs_pkg::WGT_OFS, 32'h0000_2111);
        wr(qcs_pkg::CTRL_OFS, 32'h4);
        for (int i = 0; i < 4; i++) begin
            grant(1'b1, 2'(i));
        end
        grant(1'b0, 2'h0);
        for (int i = 0; i < 4; i++) begin
            grant(1'b1, 2'(i));
        end
        grant(1'b1, 2'h3);
        grant(1'b0, 2'h0);
        // credits refilled to weights, pointer back at 0, last grant 3, q3 drained
        rd(qcs_pkg::STAT_OFS, 32'h2111_0073);
        cmp({31'h0, pop_err}, 32'h0, "pop of empty queue");
        $display("test wrr done");
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_values();
        t_port_mode();
        t_cos_mode();
        t_dscp_mode();
        t_strict();
        t_wrr();
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("unexpected at %0t: run did not finish", $time);
        complete_run();
    end
endmodule // tb_qos_queue_classifier_scheduler

`default_nettype wire
